// ==== shared/dcs_consts.svh ====
// constants for the dot clock source select block
// assumes a 12-bit byte address on the register bus
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_IDX_CSR 10'h01a
`define DCS_IDX_CTRL 10'h020
`define DCS_IDX_STAT 10'h021
`define DCS_CSR_RST 8'h07
`define DCS_CTRL_RST 8'h00
`define DCS_SRC_LSB 0
`define DCS_SRC_MSB 3
`define DCS_DIV_LSB 4
`define DCS_DIV_MSB 6
`define DCS_SCLK_BIT 7
`define DCS_DIV_OFF 3'h7
`define DCS_RESP_OK 2'h0
`define DCS_RESP_ERR 2'h2
`endif

// ==== shared/dcs_pkg.sv ====
// types for the dot clock source select block
// assumes dcs_consts.svh is included by users of the offsets
`default_nettype none
package dcs_pkg;
  typedef enum logic [3:0] {
    DCS_SRC_C0_LOOP = 4'h0,
    DCS_SRC_C1 = 4'h1,
    DCS_SRC_C2_A = 4'h2,
    DCS_SRC_C2_B = 4'h3,
    DCS_SRC_C2_ECL = 4'h4,
    DCS_SRC_PLL = 4'h5,
    DCS_SRC_OFF = 4'h6,
    DCS_SRC_C0_VGA = 4'h7
  } dcs_src_t;
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } dcs_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcs_axil_rsp_t;
  typedef struct packed {
    logic [7:0] pixel;
    logic blank;
  } dcs_latch_t;
endpackage : dcs_pkg
`default_nettype wire

// ==== rtl/dcs_top.sv ====
// dot clock source select: register slave, source mux, divider, latching
// assumes clock pins are far slower than clk and are synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.svh"

// Functional notes
// - reset loads clock selection register with 0x07, selecting clock input 0.
// - source 111 drives dot clock from input 0; software sets latch bit.
// - latch bit set: pixel bus and vga blank captured on input 0.
// - source 000 uses input 0; latch on loop clock with system blank.
// - codes 1..5 select input 1, input 2 TTL, input 2 ECL, PLL.
// - code 0110 stops dot clock; codes with bit 3 set are reserved.
// - divider field gives dot clock divided by 1..64; 111 holds zero.
// - shift clock output driven only while register bit 7 is one.
// - selected input becomes the dot clock; changeable at any time.
module dcs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcs_pkg::dcs_axil_req_t axi_req,
  output dcs_pkg::dcs_axil_rsp_t axi_rsp,
  input wire logic clock_input_zero,
  input wire logic clock_input_one,
  input wire logic clock_input_two,
  input wire logic clock_input_two_n,
  input wire logic pll_pixel_clock,
  input wire logic loop_clock_input,
  input wire logic [7:0] legacy_pixel_bus,
  input wire logic vga_blank_input,
  input wire logic system_blank_input,
  output logic dot_clock,
  output logic divided_dot_clock,
  output logic shift_clock_out,
  output logic shift_clock_oe_n,
  output dcs_pkg::dcs_latch_t latched_out,
  output logic latch_strobe
);
  // synchronisers: stage 1, stage 2, then a history stage for edges
  localparam int NS = 6;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  logic [8:0] d1_r;
  logic [8:0] d2_r;
  logic blk2_r;
  logic blk1_r;

  assign pin_raw = {loop_clock_input, pll_pixel_clock, clock_input_two_n,
                    clock_input_two, clock_input_one, clock_input_zero};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      d1_r <= '0;
      d2_r <= '0;
      blk1_r <= 1'b0;
      blk2_r <= 1'b0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= {vga_blank_input, legacy_pixel_bus};
      d2_r <= d1_r;
      blk1_r <= system_blank_input;
      blk2_r <= blk1_r;
    end
  end

  wire c0 = s2_r[0];
  wire c1 = s2_r[1];
  wire c2 = s2_r[2];
  wire c2n = s2_r[3];
  wire pll = s2_r[4];
  wire lk = s2_r[5];

  // register file
  logic [7:0] csr_r;
  logic [7:0] ctrl_r;
  wire [3:0] src = csr_r[`DCS_SRC_MSB:`DCS_SRC_LSB];
  wire [2:0] divc = csr_r[`DCS_DIV_MSB:`DCS_DIV_LSB];
  wire vga_latch_clock_sel = ctrl_r[0];

  // source mux
  logic ecl_r;
  logic dot_nxt;
  logic dot_r;
  logic dot_prev_r;
  wire ecl_valid = c2 ^ c2n;

  always_comb begin
    dot_nxt = 1'b0;
    case (src)
      dcs_pkg::DCS_SRC_C0_LOOP: dot_nxt = c0;
      dcs_pkg::DCS_SRC_C0_VGA: dot_nxt = c0;
      dcs_pkg::DCS_SRC_C1: dot_nxt = c1;
      dcs_pkg::DCS_SRC_C2_A: dot_nxt = c2;
      dcs_pkg::DCS_SRC_C2_B: dot_nxt = c2;
      dcs_pkg::DCS_SRC_C2_ECL: dot_nxt = ecl_valid ? c2 : ecl_r;
      dcs_pkg::DCS_SRC_PLL: dot_nxt = pll;
      dcs_pkg::DCS_SRC_OFF: dot_nxt = 1'b0;
      default: dot_nxt = 1'b0;
    endcase
  end

  // divider counts rising dot clock edges
  logic [5:0] cnt_r;
  logic div_nxt;
  logic div_r;
  logic shift_r;
  wire dot_rise = dot_r & ~dot_prev_r;

  always_comb begin
    case (divc)
      3'h0: div_nxt = dot_r;
      3'h1: div_nxt = cnt_r[0];
      3'h2: div_nxt = cnt_r[1];
      3'h3: div_nxt = cnt_r[2];
      3'h4: div_nxt = cnt_r[3];
      3'h5: div_nxt = cnt_r[4];
      3'h6: div_nxt = cnt_r[5];
      default: div_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ecl_r <= 1'b0;
      dot_r <= 1'b0;
      dot_prev_r <= 1'b0;
      cnt_r <= '0;
      div_r <= 1'b0;
      shift_r <= 1'b0;
    end else begin
      if (ecl_valid)
        ecl_r <= c2;
      dot_r <= dot_nxt;
      dot_prev_r <= dot_r;
      if (dot_rise)
        cnt_r <= cnt_r + 6'h01;
      div_r <= div_nxt;
      shift_r <= csr_r[`DCS_SCLK_BIT] & dot_nxt;
    end
  end

  assign dot_clock = dot_r;
  assign divided_dot_clock = div_r;
  assign shift_clock_out = shift_r;
  assign shift_clock_oe_n = ~csr_r[`DCS_SCLK_BIT];

  // pixel and blank latching
  dcs_pkg::dcs_latch_t lat_r;
  logic lat_stb_r;
  wire c0_rise = c0 & ~s3_r[0];
  wire lk_rise = lk & ~s3_r[5];
  wire lat_edge = vga_latch_clock_sel ? c0_rise : lk_rise;
  wire lat_blank = vga_latch_clock_sel ? d2_r[8] : blk2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_r <= '0;
      lat_stb_r <= 1'b0;
    end else begin
      lat_stb_r <= lat_edge;
      if (lat_edge)
        lat_r <= {d2_r[7:0], lat_blank};
    end
  end

  assign latched_out = lat_r;
  assign latch_strobe = lat_stb_r;

  // axi4-lite slave
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire awready = ~aw_hold_r & ~bvalid_r;
  wire wready = ~w_hold_r & ~bvalid_r;
  wire aw_fire = axi_req.awvalid & awready;
  wire w_fire = axi_req.wvalid & wready;
  wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [9:0] widx = awaddr_r[11:2];
  wire wr_csr = do_write & (widx == `DCS_IDX_CSR) & wstrb_r[0];
  wire wr_ctrl = do_write & (widx == `DCS_IDX_CTRL) & wstrb_r[0];
  wire w_hit = (widx == `DCS_IDX_CSR) | (widx == `DCS_IDX_CTRL);
  wire ar_fire = axi_req.arvalid & ~rvalid_r;
  wire [9:0] ridx = axi_req.araddr[11:2];
  wire src_rsvd = src[3];
  wire mode_bad = (src == 4'h7 & ~vga_latch_clock_sel) |
                  (src == 4'h0 & vga_latch_clock_sel);
  wire [7:0] stat = {4'h0, dot_r, mode_bad, src_rsvd,
                     ~(src_rsvd | src == 4'h6)};
  wire r_csr = ridx == `DCS_IDX_CSR;
  wire r_ctrl = ridx == `DCS_IDX_CTRL;
  wire r_stat = ridx == `DCS_IDX_STAT;
  wire [7:0] rsel = r_csr ? csr_r : r_ctrl ? ctrl_r : r_stat ? stat : 8'h00;
  wire r_hit = r_csr | r_ctrl | r_stat;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csr_r <= `DCS_CSR_RST;
      ctrl_r <= `DCS_CTRL_RST;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `DCS_RESP_OK;
    end else begin
      if (aw_fire) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= axi_req.awaddr;
      end
      if (w_fire) begin
        w_hold_r <= 1'b1;
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_hit ? `DCS_RESP_OK : `DCS_RESP_ERR;
      end else if (bvalid_r & axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_csr)
        csr_r <= wdata_r[7:0];
      if (wr_ctrl)
        ctrl_r <= {7'h00, wdata_r[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `DCS_RESP_OK;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rsel};
      rresp_r <= r_hit ? `DCS_RESP_OK : `DCS_RESP_ERR;
    end else if (rvalid_r & axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign axi_rsp.awready = awready;
  assign axi_rsp.wready = wready;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = ~rvalid_r;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;

  // checks
  property p_reset_value;
    @(posedge clk) !rst_n |=> csr_r == 8'h07;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("selection register not 0x07 after reset");

  property p_vga_src;
    @(posedge clk) disable iff (!rst_n)
      src == 4'h7 ##1 src == 4'h7 |-> dot_r == $past(c0);
  endproperty
  a_vga_src: assert property (p_vga_src)
    else $error("code 111 dot clock not from input 0");

  property p_vga_latch;
    @(posedge clk) disable iff (!rst_n)
      vga_latch_clock_sel && c0_rise |=>
        lat_r.pixel == $past(d2_r[7:0]) && lat_r.blank == $past(d2_r[8]);
  endproperty
  a_vga_latch: assert property (p_vga_latch)
    else $error("vga bus not latched on input 0");

  property p_loop_latch;
    @(posedge clk) disable iff (!rst_n)
      !vga_latch_clock_sel && lk_rise |=>
        latch_strobe && lat_r.blank == $past(blk2_r);
  endproperty
  a_loop_latch: assert property (p_loop_latch)
    else $error("system blank not latched on loop clock");

  property p_src_one;
    @(posedge clk) disable iff (!rst_n)
      src == 4'h1 ##1 src == 4'h1 |-> dot_r == $past(c1);
  endproperty
  a_src_one: assert property (p_src_one)
    else $error("code 0001 dot clock not from input 1");

  property p_off;
    @(posedge clk) disable iff (!rst_n)
      (src == 4'h6 || src[3]) [*2] |-> !dot_r && !shift_r;
  endproperty
  a_off: assert property (p_off)
    else $error("dot clock running while stopped");

  property p_div;
    @(posedge clk) disable iff (!rst_n)
      divc == 3'h7 |=> !div_r;
  endproperty
  a_div: assert property (p_div)
    else $error("divided output not held low");

  property p_div2;
    @(posedge clk) disable iff (!rst_n)
      divc == 3'h1 && $changed(cnt_r[0]) |-> $past(dot_rise);
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two not tied to dot edges");

  property p_shift;
    @(posedge clk) disable iff (!rst_n)
      !csr_r[7] |=> !shift_r;
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift clock driven while disabled");

  property p_write;
    @(posedge clk) disable iff (!rst_n)
      wr_csr |=> csr_r == $past(wdata_r[7:0]) && bvalid_r;
  endproperty
  a_write: assert property (p_write)
    else $error("selection write not applied");
endmodule : dcs_top
`default_nettype wire

// ==== testbench/dcs_osc_model.sv ====
// oscillator, pll and loop clock models for the clock pins
// assumes a 100 ns system clock; pin edges never meet its edges
`timescale 1ns/10ps
`default_nettype none
module dcs_osc_model #(
  parameter int H0 = 400,
  parameter int H1 = 500,
  parameter int H2 = 600,
  parameter int HP = 700,
  parameter int HL = 900
) (
  output var logic [4:0] q,
  output logic c2_n
);
  localparam int HT [5] = '{H0, H1, H2, HP, HL};
  // pll model runs from time zero, so it is locked before selection
  for (genvar i = 0; i < 5; i++) begin : g_pin
    initial begin
      q[i] = 1'b0;
      #(37 + 11 * i);
      forever #(HT[i]) q[i] = ~q[i];
    end
  end
  assign c2_n = ~q[2];
endmodule : dcs_osc_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the dot clock source select block
// assumes the oscillator model drives all clock pins
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dcs_pkg::dcs_axil_req_t req = '0;
  dcs_pkg::dcs_axil_rsp_t rsp;
  logic [4:0] q;
  logic c2n, dot, div, sh, oe_n, stb, probe;
  logic [7:0] pix = 8'h00;
  logic vb = 1'b0;
  logic sb = 1'b0;
  dcs_pkg::dcs_latch_t lat;
  logic [1:0] sel = 2'h0;
  logic [1:0] r;
  logic [31:0] d;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int p;
  int dot_per [16] = '{8, 10, 12, 12, 12, 14, 0, 8, 0, 0, 0, 0, 0, 0, 0, 0};
  always #50 clk = ~clk;
  assign probe = (sel == 2'h0) ? dot : (sel == 2'h1) ? div : sh;
  dcs_osc_model osc_u (.q(q), .c2_n(c2n));
  dcs_top dut_u (.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .clock_input_zero(q[0]), .clock_input_one(q[1]),
    .clock_input_two(q[2]), .clock_input_two_n(c2n),
    .pll_pixel_clock(q[3]), .loop_clock_input(q[4]),
    .legacy_pixel_bus(pix), .vga_blank_input(vb),
    .system_blank_input(sb), .dot_clock(dot), .divided_dot_clock(div),
    .shift_clock_out(sh), .shift_clock_oe_n(oe_n), .latched_out(lat),
    .latch_strobe(stb));
  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    logic ta, tw, tk;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tk = req.bready && rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tk) begin
        req.bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    logic ta, tk;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = req.arvalid && rsp.arready;
      tk = req.rready && rsp.rvalid;
      v = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      if (ta) req.arvalid <= 1'b0;
      if (tk) begin
        req.rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rw(input logic [7:0] v);
    wr(12'h068, {24'h0, v}, r);
    chk(32'(r), 32'h0);
    rd(12'h068, d, r);
    chk(d, {24'h0, v});
  endtask : rw
  // cycles between the first two rises seen on the probe
  task automatic meas(input logic [1:0] s, input int lim, output int per);
    int t, k;
    logic o;
    sel = s;
    per = 0;
    k = 0;
    t = 0;
    o = probe;
    for (int n = 0; n < lim && k < 2; n++) begin
      @(negedge clk);
      t++;
      if (probe === 1'b1 && o === 1'b0) begin
        if (k == 1) per = t;
        k++;
        t = 0;
      end
      o = probe;
    end
  endtask : meas
  task automatic strobes(input int n);
    int k;
    k = 0;
    for (int t = 0; t < 400 && k < n; t++) begin
      @(negedge clk);
      if (stb === 1'b1) k++;
    end
    chk(k, n);
  endtask : strobes
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h068, d, r);
    chk(d, 32'h7);
    chk(32'(oe_n), 32'h1);
    meas(2'h0, 60, p);
    chk(p, 8);
    for (int i = 0; i < 16; i++) begin
      rw({4'h8, 4'(i)});
      chk(32'(oe_n), 32'h0);
      meas(2'h0, 60, p);
      chk(p, dot_per[i]);
      meas(2'h1, 60, p);
      chk(p, dot_per[i]);
      meas(2'h2, 60, p);
      chk(p, dot_per[i]);
    end
    for (int k = 0; k < 8; k++) begin
      rw({1'b0, 3'(k), 4'h0});
      chk(32'(oe_n), 32'h1);
      meas(2'h1, 1100, p);
      chk(p, (k < 7) ? (8 << k) : 0);
    end
    meas(2'h2, 40, p);
    chk(p, 0);
    wr(12'h068, 32'h7, r);
    rd(12'h084, d, r);
    chk(d & 32'h7, 32'h5);
    wr(12'h080, 32'h1, r);
    rd(12'h084, d, r);
    chk(d & 32'h7, 32'h1);
    pix <= 8'h5a;
    vb <= 1'b1;
    strobes(2);
    chk(32'(lat), {23'h0, 8'h5a, 1'b1});
    wr(12'h080, 32'h0, r);
    wr(12'h068, 32'h0, r);
    rd(12'h084, d, r);
    chk(d & 32'h7, 32'h1);
    pix <= 8'ha5;
    strobes(2);
    chk(32'(lat), {23'h0, 8'ha5, 1'b0});
    rd(12'h040, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'h2);
    wr(12'h044, 32'hff, r);
    chk(32'(r), 32'h2);
    rw(8'hc1);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h068, d, r);
    chk(d, 32'h7);
    finish_test();
  end
endmodule : tb
`default_nettype wire
